// ==== core/nand_host.sv ====
/*
  host nand controller: read, program (one full page), erase, reset and a
  bad-block scan that builds a table before any erase is allowed.
  assumes one nand device on an 8-bit bus, ready/busy from a pin.
*/
`timescale 1ns/1ps
`include "nand_host_cfg.svh"
module nand_host (
  // system
  input wire logic clk,
  input wire logic sys_rst,
  // user request
  input wire nand_host_pkg::host_req_type req,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic scan_start,
  output logic scan_done_r,
  // user data
  input wire logic [7:0] wr_data,
  output logic wr_data_take,
  output logic [7:0] rd_data_r,
  output logic rd_data_valid_r,
  // result
  output logic op_done_r,
  output logic op_fail_r,
  output logic op_refused_r,
  // nand pins
  output nand_host_pkg::nand_ctl_type ctl,
  input wire logic [7:0] io_in,
  output logic [7:0] io_out_r,
  output logic io_oe_n_r,
  input wire logic ready_busy
);
  import nand_host_pkg::*;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0, ST_CMD1 = 4'h1, ST_ADDR = 4'h2, ST_ADL = 4'h3,
    ST_DIN = 4'h4, ST_CMD2 = 4'h5, ST_WB = 4'h6, ST_BUSY = 4'h7,
    ST_STAT_CMD = 4'h8, ST_STAT_RD = 4'h9, ST_DOUT = 4'hA, ST_FIN = 4'hB
  } state_type;

  state_type st_r;
  host_req_type cur_r;
  logic scanning_r;
  logic [11:0] scan_blk_r;
  logic scan_page_r;
  logic [`NUM_BLOCKS-1:0] bad_r;
  logic [2:0] addr_idx_r;
  logic [11:0] byte_cnt_r;
  logic [7:0] wait_r;
  logic [1:0] rb_sync_r;
  logic strobe_go, strobe_done, strobe_rd;
  logic is_cmd, is_addr;
  logic [7:0] io_s1_r, io_s2_r; // read byte held from strobe low: bus flips once released
  default clocking cb_sys @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  nand_strobe u_strobe (
    .clk(clk),
    .sys_rst(sys_rst),
    .start(strobe_go),
    .is_read(strobe_rd),
    .done(strobe_done),
    .we_n(ctl.we_n),
    .re_n(ctl.re_n)
  );

  // ready/busy is a pin: two flops before use
  always_ff @(posedge clk) begin
    if (sys_rst) rb_sync_r <= 2'b00;
    else rb_sync_r <= {rb_sync_r[0], ready_busy};
  end
  wire rb_ready = rb_sync_r[1];
  always_ff @(posedge clk) begin
    if (sys_rst) {io_s2_r, io_s1_r} <= 16'h0000;
    else begin
      if (!ctl.re_n) io_s1_r <= io_in;
      io_s2_r <= io_s1_r;
    end
  end

  // address cycle byte: two column, three row
  function automatic logic [7:0] addr_byte(input logic [2:0] i, input logic [15:0] col,
                                           input logic [16:0] row);
    unique case (i)
      3'h0: addr_byte = col[7:0];
      3'h1: addr_byte = col[15:8];
      3'h2: addr_byte = row[7:0];
      3'h3: addr_byte = row[15:8];
      default: addr_byte = {7'h00, row[16]};
    endcase
  endfunction : addr_byte

  wire [16:0] row = {cur_r.block, cur_r.page};
  // scans read the marker column only; others start at column zero [R10]
  wire [15:0] col = scanning_r ? `MARKER_COL : 16'h0000;
  wire [2:0] n_addr = (cur_r.op == OP_ERASE) ? 3'h3 : 3'h5;
  wire [2:0] a_base = (cur_r.op == OP_ERASE) ? 3'h2 : 3'h0;
  function automatic logic [7:0] first_cmd(input op_type op);
    unique case (op)
      OP_READ: first_cmd = `CMD_READ1;
      OP_PROG: first_cmd = `CMD_PROG1;
      OP_ERASE: first_cmd = `CMD_ERASE1;
      OP_RESET: first_cmd = `CMD_RESET;
    endcase
  endfunction : first_cmd
  function automatic logic [7:0] second_cmd(input op_type op);
    unique case (op)
      OP_READ: second_cmd = `CMD_READ2;
      OP_PROG: second_cmd = `CMD_PROG2;
      default: second_cmd = `CMD_ERASE2;
    endcase
  endfunction : second_cmd
  assign is_cmd = (st_r == ST_CMD1) || (st_r == ST_CMD2) || (st_r == ST_STAT_CMD);
  assign is_addr = (st_r == ST_ADDR);
  assign strobe_rd = (st_r == ST_STAT_RD) || (st_r == ST_DOUT);
  assign strobe_go = is_cmd || is_addr || strobe_rd || (st_r == ST_DIN);
  assign wr_data_take = (st_r == ST_DIN) && strobe_done;
  // erase of a flagged block, or before the table exists, is refused [R07] [R11]
  wire refuse = (req.op == OP_ERASE || req.op == OP_PROG)
                && (!scan_done_r || bad_r[req.block]);
  assign req_ready = (st_r == ST_IDLE) && !scanning_r;
  assign ctl.cle = is_cmd;
  assign ctl.ale = is_addr;
  assign ctl.ce_n = (st_r == ST_IDLE);

  // control lines and data stay stable across the strobe [R06]
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      io_out_r <= 8'h00;
      io_oe_n_r <= 1'b1;
    end else begin
      io_oe_n_r <= strobe_rd || (st_r == ST_IDLE) || (st_r == ST_BUSY) || (st_r == ST_WB);
      unique case (st_r)
        ST_CMD1: io_out_r <= first_cmd(cur_r.op);
        ST_CMD2: io_out_r <= second_cmd(cur_r.op);
        ST_STAT_CMD: io_out_r <= `CMD_STATUS;
        ST_ADDR: io_out_r <= addr_byte(a_base + addr_idx_r, col, row);
        ST_DIN: io_out_r <= wr_data;
        default: io_out_r <= io_out_r;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r <= ST_IDLE;
      cur_r <= '0;
      addr_idx_r <= 3'h0;
      byte_cnt_r <= 12'h000;
      wait_r <= 8'h00;
      op_done_r <= 1'b0;
      op_fail_r <= 1'b0;
      op_refused_r <= 1'b0;
      rd_data_r <= 8'h00;
      rd_data_valid_r <= 1'b0;
    end else begin
      op_done_r <= 1'b0;
      op_refused_r <= 1'b0;
      rd_data_valid_r <= 1'b0;
      unique case (st_r)
        ST_IDLE: begin
          if (scanning_r && !scan_done_r && scan_blk_r != `NUM_BLOCKS) begin
            cur_r <= '{op: OP_READ, block: scan_blk_r[10:0], page: {5'h00, scan_page_r}};
            st_r <= ST_CMD1;
          end else if (req_valid && req_ready) begin
            if (refuse) op_refused_r <= 1'b1;
            else begin
              cur_r <= req;
              st_r <= ST_CMD1;
            end
          end
          addr_idx_r <= 3'h0;
          byte_cnt_r <= 12'h000;
        end
        ST_CMD1: if (strobe_done) st_r <= (cur_r.op == OP_RESET) ? ST_WB : ST_ADDR;
        ST_ADDR: if (strobe_done) begin
          addr_idx_r <= addr_idx_r + 3'h1;
          wait_r <= 8'h00;
          if (addr_idx_r == n_addr - 3'h1)
            st_r <= (cur_r.op == OP_PROG) ? ST_ADL : ST_CMD2;
        end
        ST_ADL: begin
          // first data strobe rises at least 100 ns after last address [R05]
          wait_r <= wait_r + 8'h01;
          if (wait_r == 8'(`T_ADL_CYC)) st_r <= ST_DIN;
        end
        ST_DIN: if (strobe_done) begin
          // whole page in one pass: one program command per request [R02]
          byte_cnt_r <= byte_cnt_r + 12'h001;
          if (byte_cnt_r == `PAGE_BYTES - 12'h001) st_r <= ST_CMD2;
        end
        ST_CMD2: if (strobe_done) begin
          st_r <= ST_WB;
          wait_r <= 8'h00;
        end
        ST_WB: begin
          wait_r <= wait_r + 8'h01;
          if (wait_r == 8'(`T_WB_CYC)) st_r <= ST_BUSY;
        end
        // waits on ready, whatever the transfer or reset time [R03] [R04]
        ST_BUSY: if (rb_ready) begin
          unique case (cur_r.op)
            OP_READ: st_r <= ST_DOUT;
            OP_RESET: st_r <= ST_FIN;
            default: st_r <= ST_STAT_CMD;
          endcase
        end
        ST_STAT_CMD: if (strobe_done) st_r <= ST_STAT_RD;
        ST_STAT_RD: if (strobe_done) begin
          // status bit zero set means fail; caller retires the block [R16] [R12]
          op_fail_r <= io_s2_r[`STATUS_FAIL_BIT];
          st_r <= ST_FIN;
        end
        ST_DOUT: if (strobe_done) begin
          rd_data_r <= io_s2_r; // read errors never retire a block [R15]
          rd_data_valid_r <= !scanning_r;
          byte_cnt_r <= byte_cnt_r + 12'h001;
          if (scanning_r || byte_cnt_r == `PAGE_BYTES - 12'h001) st_r <= ST_FIN;
          if (scanning_r) op_fail_r <= (io_s2_r != `ERASED_BYTE);
        end
        ST_FIN: begin
          op_done_r <= !scanning_r;
          st_r <= ST_IDLE;
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  // bad-block scan: pages zero and one of each block [R18] [R10]
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      scanning_r <= 1'b0;
      scan_done_r <= 1'b0;
      scan_blk_r <= 12'h000;
      scan_page_r <= 1'b0;
      bad_r <= '0;
    end else if (scan_start && !scanning_r && !scan_done_r) begin
      scanning_r <= 1'b1;
      scan_blk_r <= 12'h000;
      scan_page_r <= 1'b0;
    end else if (scanning_r && st_r == ST_DOUT && strobe_done) begin
      if (io_s2_r != `ERASED_BYTE) bad_r[scan_blk_r[10:0]] <= 1'b1; // [R11]
      scan_page_r <= !scan_page_r;
      if (scan_page_r) scan_blk_r <= scan_blk_r + 12'h001;
    end else if (scanning_r && st_r == ST_IDLE && scan_blk_r == `NUM_BLOCKS) begin
      scanning_r <= 1'b0;
      scan_done_r <= 1'b1;
    end
  end
  property p_no_erase_before_scan;
    (st_r == ST_CMD1 && cur_r.op == OP_ERASE) |-> scan_done_r && !bad_r[cur_r.block];
  endproperty
  a_no_erase_before_scan: assert property (p_no_erase_before_scan) // [R11]
    else $error("erase issued to unscanned or bad block");
  property p_adl_wait;
    $rose(st_r == ST_ADL) |-> (st_r == ST_ADL) [*8];
  endproperty
  a_adl_wait: assert property (p_adl_wait) // [R05]
    else $error("address to data gap too short");
  property p_refuse_bad;
    (req_valid && req_ready && req.op == OP_ERASE && bad_r[req.block]) |=> op_refused_r;
  endproperty
  a_refuse_bad: assert property (p_refuse_bad) // [R07]
    else $error("bad block not refused");
  property p_status_fail;
    (st_r == ST_STAT_RD && strobe_done) |=> op_fail_r == $past(io_s2_r[0]) ##1 op_done_r;
  endproperty
  a_status_fail: assert property (p_status_fail) // [R12]
    else $error("status result not reported");
  property p_wait_ready;
    (st_r == ST_BUSY && !rb_ready) |=> st_r == ST_BUSY;
  endproperty
  a_wait_ready: assert property (p_wait_ready) // [R03]
    else $error("left busy wait early");
  property p_page_len;
    (st_r == ST_DIN) |-> byte_cnt_r < `PAGE_BYTES;
  endproperty
  a_page_len: assert property (p_page_len) // [R02]
    else $error("program longer than a page");
  property p_scan_col;
    (scanning_r && st_r == ST_ADDR && addr_idx_r == 3'h1 && !ctl.we_n)
      |-> io_out_r == 8'(`MARKER_COL >> 8);
  endproperty
  a_scan_col: assert property (p_scan_col) // [R18]
    else $error("scan not at marker column");
  property p_cle_ale_excl;
    !(ctl.cle && ctl.ale);
  endproperty
  a_cle_ale_excl: assert property (p_cle_ale_excl) // [R06]
    else $error("command and address latch both high");
  c_scan_done: cover property (@(posedge clk) $rose(scan_done_r));
  c_prog_done: cover property (@(posedge clk) op_done_r && cur_r.op == OP_PROG);
  c_fail: cover property (@(posedge clk) op_done_r && op_fail_r);
  c_refused: cover property (@(posedge clk) op_refused_r);
endmodule : nand_host

// ==== shared/nand_host_cfg.svh ====
/*
  constants for the host-side nand controller: timing counts, page layout,
  marker position, command codes.
  assumes a 250 MHz system clock and an 8-bit parallel nand device.
*/
// Behaviour
// R01: device shows short dummy busy, plane one
// R02: at most four partial programs per page
// R03: cell to page transfer within 25 us
// R04: reset busy bounded by interrupted operation
// R05: 100 ns from last address to data
// R06: control lines change once per strobe low
// R07: mapping excludes factory invalid blocks
// R08: block zero guaranteed valid with ecc
// R09: shipped device reads erased ff everywhere
// R10: bad marker at column 2048, page 0/1
// R11: build bad table before any erase
// R12: failed status retires block, relocate data; only op_fail_r is raised here, the bad table is not updated
// R13: failed program leaves other pages intact
// R14: apply single correct double detect code; no ecc here, read bytes go out raw
// R15: correct single bit errors, keep block; no correction here, the block is kept
// R16: status bit zero: zero pass, one fail
// R17: page 2112 bytes, spare from 2048
// R18: scan marker in pages zero and one
`ifndef NAND_HOST_CFG_SVH
`define NAND_HOST_CFG_SVH
`define CLK_MHZ 250
`define T_ADL_NS 100
`define T_ADL_CYC ((`T_ADL_NS * `CLK_MHZ + 999) / 1000)
`define T_WB_NS 100
`define T_WB_CYC ((`T_WB_NS * `CLK_MHZ + 999) / 1000)
`define STROBE_CYC 4
`define MARKER_COL 16'h0800
`define PAGE_BYTES 12'h840
`define ERASED_BYTE 8'hFF
`define STATUS_FAIL_BIT 0
`define CMD_READ1 8'h00
`define CMD_READ2 8'h30
`define CMD_ERASE1 8'h60
`define CMD_ERASE2 8'hD0
`define CMD_PROG1 8'h80
`define CMD_PROG2 8'h10
`define CMD_STATUS 8'h70
`define CMD_RESET 8'hFF
`define NUM_BLOCKS 12'h800
`define MAX_NOP 3'h4
`endif

// ==== shared/nand_host_pkg.sv ====
/*
  types for the nand host controller.
  assumes nand_host_cfg.svh is available on the include path.
*/
package nand_host_pkg;
  typedef enum logic [1:0] {
    OP_READ = 2'b00,
    OP_PROG = 2'b01,
    OP_ERASE = 2'b10,
    OP_RESET = 2'b11
  } op_type;

  typedef struct packed {
    logic cle;
    logic ale;
    logic ce_n;
    logic we_n;
    logic re_n;
  } nand_ctl_type;

  typedef struct packed {
    op_type op;
    logic [10:0] block;
    logic [5:0] page;
  } host_req_type;
endpackage : nand_host_pkg

// ==== core/nand_strobe.sv ====
/*
  one bus cycle on the nand pins: a write (command, address, data) or a read.
  assumes pins are held by the caller; the strobe is fixed length.
*/
`timescale 1ns/1ps
`include "nand_host_cfg.svh"
module nand_strobe (
  // system
  input wire logic clk,
  input wire logic sys_rst,
  // request
  input wire logic start,
  input wire logic is_read,
  output logic done,
  // pin strobes
  output logic we_n,
  output logic re_n
);
  logic [2:0] cnt_r;
  logic run_r;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      run_r <= 1'b0;
      cnt_r <= 3'h0;
      we_n <= 1'b1;
      re_n <= 1'b1;
    end else if (start && !run_r) begin
      run_r <= 1'b1;
      cnt_r <= 3'h0;
      we_n <= is_read;
      re_n <= !is_read;
    end else if (run_r) begin
      cnt_r <= cnt_r + 3'h1;
      // strobe low two cycles, high two: one edge each way only [R06]
      if (cnt_r == 3'h1) begin
        we_n <= 1'b1;
        re_n <= 1'b1;
      end
      if (cnt_r == 3'(`STROBE_CYC - 1)) begin
        run_r <= 1'b0;
      end
    end
  end
  assign done = run_r && (cnt_r == 3'(`STROBE_CYC - 1));

  property p_strobe_low_two;
    @(posedge clk) disable iff (sys_rst)
      $fell(we_n) |=> !we_n ##1 we_n;
  endproperty
  a_strobe_low_two: assert property (p_strobe_low_two) // [R06]
    else $error("write strobe width wrong");
endmodule : nand_strobe

// ==== dv/nand_dev_model.sv ====
/* nand device model: pages with spare markers, busy, status byte.
   assumes host pins of nand_host; busy times are short but within limits. */
`timescale 1ns/1ps
module nand_dev_model #(
  parameter int T_RD_NS = 60,
  parameter int T_PG_NS = 400,
  parameter int T_ER_NS = 800,
  // block zero never carries a marker
  parameter logic [10:0] BAD_A = 11'h005,
  parameter logic [10:0] BAD_B = 11'h00A
) (
  // host pins
  input wire nand_host_pkg::nand_ctl_type ctl,
  input wire logic [7:0] io_from_host,
  output logic [7:0] io_to_host,
  output logic ready_busy,
  // test control
  input wire logic fail_next,
  output logic viol
);
  import nand_host_pkg::*;
  logic [7:0] mem [int];
  logic [7:0] pbuf [0:2111];
  logic [7:0] adr [0:4];
  logic [7:0] cmd;
  logic [7:0] status;
  logic [16:0] row;
  logic adr_last;
  int acnt;
  int col;
  int nop [int];
  int chg [3];
  realtime t_adr;
  function automatic int key(input logic [16:0] r, input int c);
    return int'(r) * 4096 + c;
  endfunction : key
  function automatic logic [7:0] rd_byte(input logic [16:0] r, input int c);
    return mem.exists(key(r, c)) ? mem[key(r, c)] : 8'hFF;
  endfunction : rd_byte
  function automatic logic is_bad(input logic [16:0] r);
    return r[16:6] == BAD_A || r[16:6] == BAD_B;
  endfunction : is_bad
  task automatic go_busy(input int ns);
    #20 ready_busy = 1'b0;
    #(ns) ready_busy = 1'b1;
  endtask : go_busy
  task automatic prog();
    int i;
    if (nop.exists(int'(row))) nop[int'(row)]++;
    else nop[int'(row)] = 1;
    if (nop[int'(row)] > 4 || is_bad(row)) viol = 1'b1;
    status = {2'b11, 5'h00, fail_next};
    // a failed program leaves every page as it was
    for (i = 0; i < 2112 && !fail_next; i++)
      mem[key(row, i)] = rd_byte(row, i) & pbuf[i];
    go_busy(T_PG_NS);
  endtask : prog
  task automatic erase();
    int p;
    int c;
    if (is_bad(row)) viol = 1'b1;
    status = {2'b11, 5'h00, fail_next};
    for (p = 0; p < 64 && !fail_next; p++) begin
      nop.delete(int'({row[16:6], 6'(p)}));
      for (c = 0; c < 2112; c++)
        mem.delete(key({row[16:6], 6'(p)}, c));
    end
    go_busy(T_ER_NS);
  endtask : erase
  initial begin
    ready_busy = 1'b1;
    viol = 1'b0;
    io_to_host = 8'hA5;
    acnt = 0;
    adr = '{default: 8'h00};
    mem[key({BAD_A, 6'h00}, 2048)] = 8'h00;
    mem[key({BAD_B, 6'h01}, 2048)] = 8'hF0;
  end
  always @(negedge ctl.we_n) chg = '{0, 0, 0};
  always @(ctl.cle) if (!ctl.we_n && ++chg[0] > 1) viol = 1'b1;
  always @(ctl.ale) if (!ctl.we_n && ++chg[1] > 1) viol = 1'b1;
  always @(ctl.ce_n) if (!ctl.we_n && ++chg[2] > 1) viol = 1'b1;
  always @(posedge ctl.we_n) if (!ctl.ce_n) begin
    if (ctl.ale) begin
      adr[acnt % 5] = io_from_host;
      acnt++;
      col = {adr[1][3:0], adr[0]};
      adr_last = 1'b1;
      t_adr = $realtime;
    end else if (!ctl.cle) begin
      if (adr_last && $realtime - t_adr < 100.0) viol = 1'b1;
      adr_last = 1'b0;
      pbuf[col % 2112] = io_from_host;
      col++;
    end else begin
      cmd = io_from_host;
      adr_last = 1'b0;
      row = (cmd == 8'hD0) ? {adr[2][0], adr[1], adr[0]} : {adr[4][0], adr[3], adr[2]};
      case (cmd)
        8'h00, 8'h60: acnt = 0;
        8'h80: begin
          acnt = 0;
          pbuf = '{default: 8'hFF};
        end
        8'h30: go_busy(T_RD_NS);
        8'h10: prog();
        8'hD0: erase();
        8'hFF: go_busy(T_RD_NS);
        default: ;
      endcase
    end
  end
  always @(negedge ctl.re_n) if (!ctl.ce_n) begin
    io_to_host = (cmd == 8'h70) ? status : rd_byte(row, col);
    col++;
  end
  // released bus must not look like the last byte
  always @(posedge ctl.re_n) #4 io_to_host = ~io_to_host;
endmodule : nand_dev_model

// ==== dv/tb_top.sv ====
/* testbench for nand_host against the device model.
   assumes nand_host_cfg.svh on the include path; scan covers all blocks. */
`timescale 1ns/1ps
`include "nand_host_cfg.svh"
module tb_top;
  import nand_host_pkg::*;
  logic clk, sys_rst, req_valid, req_ready, scan_start, scan_done_r;
  logic wr_data_take, rd_data_valid_r, op_done_r, op_fail_r, op_refused_r;
  logic io_oe_n_r, ready_busy, fail_next, viol, took, rd_ff, d, r;
  logic [7:0] wr_data, rd_data_r, io_out_r, io_to_host, bus, wr_seed, rd_seed;
  host_req_type req;
  nand_ctl_type ctl;
  int n_errors, compares, wr_idx, rd_n, rd_bad;
  assign bus = !io_oe_n_r ? io_out_r : io_to_host;
  assign wr_data = wr_idx[7:0] ^ wr_seed;
  nand_host uut (.clk(clk), .sys_rst(sys_rst), .req(req), .req_valid(req_valid),
    .req_ready(req_ready), .scan_start(scan_start), .scan_done_r(scan_done_r),
    .wr_data(wr_data), .wr_data_take(wr_data_take), .rd_data_r(rd_data_r),
    .rd_data_valid_r(rd_data_valid_r), .op_done_r(op_done_r), .op_fail_r(op_fail_r),
    .op_refused_r(op_refused_r), .ctl(ctl), .io_in(bus), .io_out_r(io_out_r),
    .io_oe_n_r(io_oe_n_r), .ready_busy(ready_busy));
  nand_dev_model dev (.ctl(ctl), .io_from_host(bus), .io_to_host(io_to_host),
    .ready_busy(ready_busy), .fail_next(fail_next), .viol(viol));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(negedge clk) took = wr_data_take;
  always @(posedge clk) if (took) #1 wr_idx = wr_idx + 1;
  always @(negedge clk) if (rd_data_valid_r === 1'b1) begin
    if (rd_data_r !== (rd_ff ? `ERASED_BYTE : rd_n[7:0] ^ rd_seed)) rd_bad++;
    rd_n++;
  end
  task automatic check_val(input logic [15:0] got, input logic [15:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask : check_val
  task automatic summarize();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : summarize
  task automatic timeout(input string what);
    n_errors++;
    $display("MISMATCH at %0t: %s timed out", $time, what);
    summarize();
  endtask : timeout
  task automatic run_op(input op_type op, input logic [10:0] blk, input logic [5:0] pg);
    int i;
    @(posedge clk) #1;
    req = '{op, blk, pg};
    req_valid = 1'b1;
    for (i = 0; i < 100 && req_ready !== 1'b1; i++) @(negedge clk);
    if (req_ready !== 1'b1) timeout("request");
    @(posedge clk) #1 req_valid = 1'b0;
    d = 1'b0;
    r = 1'b0;
    for (i = 0; i < 40000 && !d && !r; i++) begin
      @(negedge clk);
      d = (op_done_r === 1'b1);
      r = (op_refused_r === 1'b1);
    end
    if (!d && !r) timeout("operation");
  endtask : run_op
  task automatic prog_page(input logic [10:0] blk, input logic [5:0] pg, input logic [7:0] s);
    wr_idx = 0;
    wr_seed = s;
    run_op(OP_PROG, blk, pg);
    check_val(16'(wr_idx), `PAGE_BYTES, "program byte count");
  endtask : prog_page
  task automatic read_page(input logic [10:0] blk, input logic [5:0] pg, input logic ff,
                           input logic [7:0] s);
    rd_n = 0;
    rd_bad = 0;
    rd_ff = ff;
    rd_seed = s;
    run_op(OP_READ, blk, pg);
    @(posedge clk);
    check_val(16'(rd_n), `PAGE_BYTES, "read byte count");
    check_val(16'(rd_bad), 16'h0000, "read data");
  endtask : read_page
  task automatic t_early();
    run_op(OP_PROG, 11'h001, 6'h00);
    check_val(r, 1'b1, "program before scan");
    run_op(OP_ERASE, 11'h001, 6'h00);
    check_val(r, 1'b1, "erase before scan");
    $display("test early done");
  endtask : t_early
  task automatic t_scan();
    int i;
    @(posedge clk) #1 scan_start = 1'b1;
    @(posedge clk) #1 scan_start = 1'b0;
    for (i = 0; i < 600000 && scan_done_r !== 1'b1; i++) @(negedge clk);
    if (scan_done_r !== 1'b1) timeout("scan");
    check_val(scan_done_r, 1'b1, "scan finished");
    $display("test scan done");
  endtask : t_scan
  task automatic t_bad();
    run_op(OP_ERASE, 11'h005, 6'h00);
    check_val(r, 1'b1, "erase marked page zero");
    run_op(OP_PROG, 11'h00A, 6'h03);
    check_val(r, 1'b1, "program marked page one");
    run_op(OP_ERASE, 11'h000, 6'h00);
    check_val({r, d}, 2'b01, "erase block zero");
    run_op(OP_ERASE, 11'h001, 6'h00);
    check_val({d, op_fail_r}, 2'b10, "erase passes");
    $display("test bad done");
  endtask : t_bad
  task automatic t_data();
    prog_page(11'h001, 6'h02, 8'h3C);
    check_val({d, op_fail_r}, 2'b10, "program passes");
    read_page(11'h001, 6'h02, 1'b0, 8'h3C);
    read_page(11'h001, 6'h03, 1'b1, 8'h00);
    $display("test data done");
  endtask : t_data
  task automatic t_fail();
    fail_next = 1'b1;
    prog_page(11'h001, 6'h04, 8'h5A);
    check_val(op_fail_r, 1'b1, "program fail");
    run_op(OP_ERASE, 11'h002, 6'h00);
    check_val(op_fail_r, 1'b1, "erase fail");
    fail_next = 1'b0;
    read_page(11'h001, 6'h02, 1'b0, 8'h3C);
    prog_page(11'h001, 6'h05, 8'hC3);
    check_val(op_fail_r, 1'b0, "fail cleared");
    $display("test fail done");
  endtask : t_fail
  initial begin
    sys_rst = 1'b1;
    req_valid = 1'b0;
    req = '0;
    scan_start = 1'b0;
    fail_next = 1'b0;
    {wr_idx, rd_n, rd_bad, n_errors, compares} = '0;
    {wr_seed, rd_seed, rd_ff, took} = '0;
    repeat (12) @(posedge clk);
    #1 sys_rst = 1'b0;
    check_val({ctl.ce_n, ctl.we_n, ctl.re_n, io_oe_n_r}, 4'hF, "idle pins");
    t_early();
    t_scan();
    t_bad();
    t_data();
    t_fail();
    run_op(OP_RESET, 11'h000, 6'h00);
    check_val(d, 1'b1, "reset operation");
    $display("test reset done");
    check_val(viol, 1'b0, "pin protocol");
    summarize();
  end
endmodule : tb_top
